// *** rtl/alu_ops_pkg.sv ***
// package of opcodes, states, widths and reset values for the subtract/swap/xor datapath
package alu_ops_pkg;
    // operation select from the decoder
    typedef enum logic [2:0] {
        OP_NONE            = 3'b000,
        OP_SUB_FILE        = 3'b001,
        OP_SUB_LITERAL     = 3'b010,
        OP_SUB_BORROW      = 3'b011,
        OP_NIBBLE_SWAP     = 3'b100,
        OP_DIRECTION_LOAD  = 3'b101,
        OP_XOR_LITERAL     = 3'b110,
        OP_XOR_FILE        = 3'b111
    } alu_op_t;

    // datapath state
    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_BUSY = 1'b1
    } alu_state_t;

    localparam int          DATA_W           = 8;
    localparam int          FILE_ADDR_W      = 7;
    localparam logic [6:0]  FILE_ADDR_MAX    = 7'h7f;
    localparam logic [2:0]  DIR_SEL_FIRST    = 3'h5;
    localparam logic [2:0]  DIR_SEL_SECOND   = 3'h6;
    localparam logic [2:0]  DIR_SEL_THIRD    = 3'h7;
    localparam logic        DEST_WREG        = 1'h0;
    localparam logic        DEST_FILE        = 1'h1;
    localparam logic [7:0]  WREG_RESET       = 8'h00;
    localparam logic [7:0]  DIR_RESET        = 8'hff;
    localparam logic        FLAG_RESET       = 1'h0;
    localparam int          NIBBLE_LO_MSB    = 3;
    localparam int          NIBBLE_HI_LSB    = 4;
    localparam int          OP_LATENCY       = 1;
endpackage

// *** rtl/alu_result_if.sv ***
// interface carrying one result word and its write targets between datapath and store
`timescale 1ns/100ps
interface alu_result_if;
    logic       valid;      // one-cycle result strobe
    logic [7:0] data;       // result value
    logic       to_file;    // write to file register
    logic       to_wreg;    // write to working register
    logic [2:0] dir_sel;    // direction register select
    logic       to_dir;     // write to direction register
    modport src (output valid, data, to_file, to_wreg, dir_sel, to_dir);
    modport dst (input  valid, data, to_file, to_wreg, dir_sel, to_dir);
endinterface

// *** rtl/dir_reg_store.sv ***
// three port direction registers loaded from the result channel
`timescale 1ns/100ps
module dir_reg_store
    import alu_ops_pkg::*;
(
    input  wire logic       i_core_clk,  // core clock
    input  wire logic       i_reset,     // async reset, high
    alu_result_if.dst       res,         // result channel
    output logic [7:0]      o_dir_first, // first port direction
    output logic [7:0]      o_dir_second,// second port direction
    output logic [7:0]      o_dir_third  // third port direction
);
    ////////////////////////////////////////////////////////////////////////////
    // select decode
    wire ld_first  = res.valid && res.to_dir && (res.dir_sel == DIR_SEL_FIRST);
    wire ld_second = res.valid && res.to_dir && (res.dir_sel == DIR_SEL_SECOND);
    wire ld_third  = res.valid && res.to_dir && (res.dir_sel == DIR_SEL_THIRD);

    ////////////////////////////////////////////////////////////////////////////
    // direction registers, all inputs after reset
    always_ff @(posedge i_core_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            o_dir_first  <= DIR_RESET;
            o_dir_second <= DIR_RESET;
            o_dir_third  <= DIR_RESET;
        end
        else
        begin
            if (ld_first)
                o_dir_first <= res.data;
            if (ld_second)
                o_dir_second <= res.data;
            if (ld_third)
                o_dir_third <= res.data;
        end
    end
endmodule

// *** rtl/sub_swap_xor_alu.sv ***
// subtract, nibble swap, direction load and xor execution datapath
// Overview of operation
// - file minus working register, seven-bit address
// - destination bit 0 working, 1 file
// - carry/digit carry set when no borrow
// - literal minus working register into working
// - borrow subtract also takes inverted carry
// - direction load by select 5,6,7; flags kept
// - literal xor into working, zero only
// - file xor per destination, zero only
`timescale 1ns/100ps
module sub_swap_xor_alu
    import alu_ops_pkg::*;
(
    input  wire logic        i_core_clk,    // core instruction clock
    input  wire logic        i_reset,       // async reset, high
    input  wire logic        i_valid,       // instruction strobe
    input  wire logic [2:0]  i_op,          // operation select
    input  wire logic [6:0]  i_file_addr,   // file address / direction select
    input  wire logic        i_dest,        // destination bit
    input  wire logic [7:0]  i_literal,     // immediate operand
    input  wire logic [7:0]  i_file_data,   // addressed file register value
    output logic             o_done,        // result strobe
    output logic [7:0]       o_wreg,        // working register
    output logic             o_file_we,     // file write strobe
    output logic [6:0]       o_file_addr,   // file write address
    output logic [7:0]       o_file_wdata,  // file write data
    output logic             o_carry,       // carry flag
    output logic             o_digit_carry_flag, // digit carry flag
    output logic             o_zero,        // zero flag
    output logic [7:0]       o_port_first_direction,  // first port direction
    output logic [7:0]       o_port_second_direction, // second port direction
    output logic [7:0]       o_port_third_direction   // third port direction
);
    ////////////////////////////////////////////////////////////////////////////
    // timing and hazards
    //
    // one request per clock, taken at the rising edge where i_valid is high
    // and the code is not zero; every operand is sampled at that same edge.
    // working register, flags, direction registers and the file write port
    // all show the result right after that same edge, together with the o_done pulse.
    // a request in the very next cycle already sees the new working register
    // and carry, so the decoder needs no stall between instructions.
    // the file bank takes the write-back one edge late; a read of the same
    // address in the cycle right after a write-back still sees the old value.

    ////////////////////////////////////////////////////////////////////////////
    // helpers
    //
    // both subtract helpers add the minuend, the inverted subtrahend and the
    // inverted borrow-in; a clear borrow-in gives the plain difference, and
    // the top bit (8 for the byte, 4 for the nibble) is the no-borrow flag

    // minuend - subtrahend - borrow, 9-bit with no-borrow in bit 8
    function automatic logic [8:0] sub_nb(input logic [7:0] a, input logic [7:0] b,
                                         input logic bin);
        sub_nb = {1'b0, a} + {1'b0, ~b} + {8'h00, ~bin};
    endfunction

    // low nibble no-borrow
    function automatic logic nib_nb(input logic [7:0] a, input logic [7:0] b,
                                    input logic bin);
        logic [4:0] s;
        s = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + {4'h0, ~bin};
        nib_nb = s[4];
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // state
    logic [7:0]  wreg_q;     // working register
    logic        carry_q;    // carry
    logic        dc_q;       // digit carry
    logic        zero_q;     // zero
    alu_state_t  state_q;       // idle or result pending
    alu_state_t  state_d;       // next state
    logic        file_we_q;     // file write strobe, one cycle
    logic [6:0]  file_addr_q;   // file write address, held
    logic [7:0]  file_wdata_q;  // file write data, held
    alu_op_t     op;            // typed operation

    alu_result_if res ();    // channel to direction store

    // all eight codes are named, so the cast never yields a stray value
    assign op = alu_op_t'(i_op);

    ////////////////////////////////////////////////////////////////////////////
    // operand and result selection
    // decode of the operation class; the empty code matches none of these
    wire        is_lit_sub  = (op == OP_SUB_LITERAL);
    wire        is_borrow   = (op == OP_SUB_BORROW);
    wire        is_sub      = (op == OP_SUB_FILE) || is_lit_sub || is_borrow;
    wire        is_xor      = (op == OP_XOR_LITERAL) || (op == OP_XOR_FILE);
    wire        is_swap     = (op == OP_NIBBLE_SWAP);
    wire        is_dir      = (op == OP_DIRECTION_LOAD);
    wire        uses_lit    = is_lit_sub || (op == OP_XOR_LITERAL);
    // minuend is literal for literal forms, else the file register
    wire [7:0]  operand_a   = uses_lit ? i_literal : i_file_data;
    // plain subtracts run with borrow-in clear; the borrow form takes one more
    // away when carry is clear, since carry set means no borrow
    wire        borrow_in   = is_borrow ? ~carry_q : 1'b0;
    // byte and low nibble share the borrow-in, so digit carry tracks carry
    // on the borrow form as well
    wire [8:0]  diff        = sub_nb(operand_a, wreg_q, borrow_in);
    wire        nib_ok      = nib_nb(operand_a, wreg_q, borrow_in);
    // swap always reads the file operand, never the literal
    wire [7:0]  swapped     = {i_file_data[NIBBLE_LO_MSB:0],
                               i_file_data[7:NIBBLE_HI_LSB]};
    wire [7:0]  xored       = wreg_q ^ operand_a;
    // swap and direction load keep carry and digit carry; xor touches zero only
    // direction load passes the working register through unchanged
    wire [7:0]  result      = is_sub  ? diff[7:0] :
                              is_xor  ? xored :
                              is_swap ? swapped : wreg_q;
    // literal forms always go to working; direction load goes to neither; others follow destination bit
    wire        go_file     = !uses_lit && !is_dir && (i_dest == DEST_FILE);
    wire        go_wreg     = !is_dir && (uses_lit || (i_dest == DEST_WREG));
    // a strobe with the empty code is a bubble: nothing changes, no done pulse
    wire        take        = i_valid && (op != OP_NONE);
    wire        set_zero    = is_sub || is_xor;
    wire        res_zero    = (result == 8'h00);

    ////////////////////////////////////////////////////////////////////////////
    // working register and flags
    // flags sit beside the working register so a back-to-back borrow subtract
    // sees the carry left by the instruction just before it
    always_ff @(posedge i_core_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            wreg_q  <= WREG_RESET;
            carry_q <= FLAG_RESET;
            dc_q    <= FLAG_RESET;
            zero_q  <= FLAG_RESET;
        end
        else if (take)
        begin
            // working register written only when it is the destination
            if (go_wreg)
                wreg_q <= result;
            // carry and digit carry change on subtracts only
            if (is_sub)
            begin
                carry_q <= diff[8];
                dc_q    <= nib_ok;
            end
            // zero follows every subtract and xor result
            if (set_zero)
                zero_q <= res_zero;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // next state: busy for exactly the cycle after an accepted request
    always_comb
    begin
        state_d = ST_IDLE;
        case (state_q)
            ST_IDLE:
                state_d = take ? ST_BUSY : ST_IDLE;   // accepted request, result next cycle
            ST_BUSY:
                state_d = take ? ST_BUSY : ST_IDLE;   // back-to-back request keeps busy
            default:
                state_d = ST_IDLE;                    // recover from any stray code
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // file write port and result strobe, one cycle after the request
    always_ff @(posedge i_core_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            state_q      <= ST_IDLE;
            file_we_q    <= 1'b0;
            file_addr_q  <= 7'h00;
            file_wdata_q <= 8'h00;
        end
        else
        begin
            state_q   <= state_d;
            file_we_q <= take && go_file;
            // address and data hold between writes so the bank may sample late
            if (take && go_file)
            begin
                file_addr_q  <= i_file_addr;
                file_wdata_q <= result;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // direction load channel: selects other than 5..7 are ignored
    // the loaded value is the working register as it stands at the request
    // edge; an address with any upper bit set maps to select zero, which no
    // direction register answers
    assign res.valid   = take;
    assign res.data    = wreg_q;
    assign res.to_file = go_file;
    assign res.to_wreg = go_wreg;
    assign res.to_dir  = is_dir;
    assign res.dir_sel = i_file_addr[2:0] & {3{i_file_addr[6:3] == 4'h0}};

    dir_reg_store u_dir (
        .i_core_clk   (i_core_clk),
        .i_reset      (i_reset),
        .res          (res),
        .o_dir_first  (o_port_first_direction),
        .o_dir_second (o_port_second_direction),
        .o_dir_third  (o_port_third_direction)
    );

    ////////////////////////////////////////////////////////////////////////////
    // outputs
    assign o_done             = (state_q == ST_BUSY);
    // file write port straight from its registers
    assign o_file_we          = file_we_q;
    assign o_file_addr        = file_addr_q;
    assign o_file_wdata       = file_wdata_q;
    assign o_wreg             = wreg_q;
    assign o_carry            = carry_q;
    assign o_digit_carry_flag = dc_q;
    assign o_zero             = zero_q;
endmodule

// *** testbench/alu_ops_monitor.sv ***
// concurrent checks on the datapath top-level ports
`timescale 1ns/100ps
module alu_ops_monitor
    import alu_ops_pkg::*;
(
    input  wire logic       i_core_clk,   // clock
    input  wire logic       i_reset,      // reset
    input  wire logic       i_valid,      // strobe
    input  wire logic [2:0] i_op,         // op
    input  wire logic       i_dest,       // destination
    input  wire logic [7:0] i_literal,    // immediate
    input  wire logic [7:0] i_file_data,  // file value
    input  wire logic       o_file_we,    // file write
    input  wire logic [7:0] o_file_wdata, // write data
    input  wire logic [7:0] o_wreg,       // working register
    input  wire logic       o_carry,      // carry
    input  wire logic       o_zero        // zero
);
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (i_reset);
    logic [7:0] swap_q; // nibble-swapped copy of the operand
    // keep the swapped operand for the next edge
    always_ff @(posedge i_core_clk)
    begin
        swap_q <= {i_file_data[3:0], i_file_data[7:4]};
    end
    property p_sub;
        i_valid && i_op == 3'h1 && i_dest
        |=> o_file_we && o_file_wdata == $past(i_file_data) - $past(o_wreg); endproperty
    a_sub: assert property (p_sub) else $error("file subtract wrong");
    property p_dst;
        i_valid && i_op inside {3'h1, 3'h3, 3'h4, 3'h7} && !i_dest |=> !o_file_we; endproperty
    a_dst: assert property (p_dst) else $error("file written for w dest");
    property p_cy;
        i_valid && i_op == 3'h1 |=> o_carry == ($past(o_wreg) <= $past(i_file_data)); endproperty
    a_cy: assert property (p_cy) else $error("carry wrong");
    property p_lit;
        i_valid && i_op == 3'h2 |=> o_wreg == $past(i_literal) - $past(o_wreg); endproperty
    a_lit: assert property (p_lit) else $error("literal subtract wrong");
    property p_brw;
        i_valid && i_op == 3'h3 && !i_dest
        |=> o_wreg == $past(i_file_data) - $past(o_wreg) - {7'h00, !$past(o_carry)}; endproperty
    a_brw: assert property (p_brw) else $error("borrow subtract wrong");
    property p_dir;
        i_valid && i_op == 3'h5 |=> $stable({o_carry, o_zero, o_wreg}); endproperty
    a_dir: assert property (p_dir) else $error("direction load touched flags");
    property p_xl;
        i_valid && i_op == 3'h6 |=> o_wreg == ($past(i_literal) ^ $past(o_wreg)) && $stable(o_carry);
    endproperty
    a_xl: assert property (p_xl) else $error("literal xor wrong");
    property p_xf;
        i_valid && i_op == 3'h7 && i_dest |=> o_file_wdata == ($past(i_file_data) ^ $past(o_wreg));
    endproperty
    a_xf: assert property (p_xf) else $error("file xor wrong");
    property p_sw;
        i_valid && i_op == 3'h4 && !i_dest |=> o_wreg == swap_q; endproperty
    a_sw: assert property (p_sw) else $error("nibble swap wrong");
    property p_z;
        i_valid && (i_op == 3'h2 || i_op == 3'h6) |=> o_zero == (o_wreg == 8'h00); endproperty
    a_z: assert property (p_z) else $error("zero flag wrong");
endmodule
bind sub_swap_xor_alu alu_ops_monitor u_mon (
    .i_core_clk   (i_core_clk),
    .i_reset      (i_reset),
    .i_valid      (i_valid),
    .i_op         (i_op),
    .i_dest       (i_dest),
    .i_literal    (i_literal),
    .i_file_data  (i_file_data),
    .o_file_we    (o_file_we),
    .o_file_wdata (o_file_wdata),
    .o_wreg       (o_wreg),
    .o_carry      (o_carry),
    .o_zero       (o_zero)
);

// *** testbench/file_reg_model.sv ***
// behavioural file register bank on the far side of the datapath
`timescale 1ns/100ps
module file_reg_model
(
    input  wire logic       i_core_clk, // core clock
    input  wire logic [6:0] i_addr,     // read address
    input  wire logic       i_we,       // write strobe
    input  wire logic [6:0] i_waddr,    // write address
    input  wire logic [7:0] i_wdata,    // write data
    output logic [7:0]      o_rdata     // addressed value
);
    logic [7:0] mem_q [128]; // each location starts holding its own address
    initial foreach (mem_q[i]) mem_q[i] = 8'(i);
    assign o_rdata = mem_q[i_addr];
    // take write-backs on the strobe
    always @(posedge i_core_clk) if (i_we) mem_q[i_waddr] <= i_wdata;
endmodule

// *** testbench/tb_sub_swap_xor_alu.sv ***
// self-checking bench for the subtract/swap/xor datapath
`timescale 1ns/100ps
module tb_sub_swap_xor_alu;
    import alu_ops_pkg::*;
    logic       i_core_clk  = 1'b0;  // core clock
    logic       i_reset     = 1'b1;  // reset, held at start
    logic       i_valid     = 1'b0;  // request strobe
    logic [2:0] i_op        = 3'h0;  // op select
    logic [6:0] i_file_addr = 7'h00; // address or select
    logic       i_dest      = 1'b0;  // destination bit
    logic [7:0] i_literal   = 8'h00; // immediate
    logic [7:0] i_file_data;         // from file model
    logic       o_done, o_file_we, o_carry, o_digit_carry_flag, o_zero; // strobes, flags
    logic [6:0] o_file_addr;         // write address
    logic [7:0] o_file_wdata, o_wreg, o_port_first_direction, o_port_second_direction;
    logic [7:0] o_port_third_direction; // third direction
    wire  [2:0] flags = {o_carry, o_digit_carry_flag, o_zero}; // carry, digit carry, zero
    int         fail_count = 0;      // mismatches
    int         num_checks = 0;      // comparisons
    // rows: op, address, dest, literal, expected working reg, expected flags
    logic [35:0] rows [10] = '{36'h200005056, 36'h103000fe0, 36'h310000110, 36'h200011007,
        36'h60003c3c6, 36'h5060003c6, 36'h73c000007, 36'h412000217, 36'h322000016,
        36'h0000ff016};
    sub_swap_xor_alu uut (
        .i_core_clk              (i_core_clk),
        .i_reset                 (i_reset),
        .i_valid                 (i_valid),
        .i_op                    (i_op),
        .i_file_addr             (i_file_addr),
        .i_dest                  (i_dest),
        .i_literal               (i_literal),
        .i_file_data             (i_file_data),
        .o_done                  (o_done),
        .o_wreg                  (o_wreg),
        .o_file_we               (o_file_we),
        .o_file_addr             (o_file_addr),
        .o_file_wdata            (o_file_wdata),
        .o_carry                 (o_carry),
        .o_digit_carry_flag      (o_digit_carry_flag),
        .o_zero                  (o_zero),
        .o_port_first_direction  (o_port_first_direction),
        .o_port_second_direction (o_port_second_direction),
        .o_port_third_direction  (o_port_third_direction)
    );
    file_reg_model u_file (.i_core_clk(i_core_clk), .i_addr(i_file_addr), .i_we(o_file_we),
        .i_waddr(o_file_addr), .i_wdata(o_file_wdata), .o_rdata(i_file_data));
    always #25 i_core_clk = ~i_core_clk;
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one request per call, outputs settled on return
    task automatic run(input logic [2:0] o, input logic [6:0] a, input logic d,
        input logic [7:0] k);
        @(negedge i_core_clk);
        {i_valid, i_op, i_file_addr, i_dest, i_literal} = {1'b1, o, a, d, k};
        @(negedge i_core_clk);
        i_valid = 1'b0;
    endtask
    task summarize;
        if (fail_count == 0 && num_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // watchdog sized well past the whole sequence
    initial
    begin
        #20000;
        fail_count++;
        summarize;
    end
    initial
    begin
        repeat (12) @(negedge i_core_clk);
        chk(o_wreg, 8'h00);
        chk(o_port_first_direction, 8'hff);
        i_reset = 1'b0;
        // every op code in turn, working register and flags chained
        foreach (rows[i])
        begin
            run(rows[i][34:32], rows[i][30:24], rows[i][20], rows[i][19:12]);
            chk(o_wreg, rows[i][11:4]);
            chk(flags, rows[i][2:0]);
            chk(o_done, rows[i][34:32] != 3'h0);
        end
        run(3'h1, 7'h7f, 1'b1, 8'h00);
        chk({o_file_we, o_file_addr, o_file_wdata, o_wreg}, 24'hff_7e_01);
        run(3'h7, 7'h40, 1'b1, 8'h00);
        chk(o_file_wdata, 8'h41);
        run(3'h4, 7'h7f, 1'b1, 8'h00);
        chk(o_file_wdata, 8'he7);
        run(3'h5, 7'h04, 1'b0, 8'h00);
        run(3'h5, 7'h07, 1'b0, 8'h00);
        chk(o_port_first_direction, 8'hff);
        chk(o_port_second_direction, 8'h3c);
        chk(o_port_third_direction, 8'h01);
        @(negedge i_core_clk);
        i_reset = 1'b1;
        @(negedge i_core_clk);
        chk(o_port_third_direction, 8'hff);
        chk(o_wreg, 8'h00);
        summarize;
    end
endmodule
